/* File: pkg/sgc_cfg.svh */
// Constants of the global switch control block: offsets, fields, resets and timing.
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH
// ********************************************************
// Register indices and APB byte addresses
// ********************************************************
`define SGC_IDX_GC0 8'h02
`define SGC_IDX_GC1 8'h03
`define SGC_ADDR_GC0 ({4'h0, `SGC_IDX_GC0} << 2)
`define SGC_ADDR_GC1 ({4'h0, `SGC_IDX_GC1} << 2)
// ********************************************************
// Field positions
// ********************************************************
`define SGC_B_SHARE 2
`define SGC_B_FILTER 1
`define SGC_B_LINKAGE 0
`define SGC_B_PASSALL 7
`define SGC_B_TXDIS 5
`define SGC_B_RXDIS 4
`define SGC_B_LENCHK 3
`define SGC_B_AGEEN 2
`define SGC_B_FASTAGE 1
`define SGC_B_BACKOFF 0
// ********************************************************
// Reset values and strap pull defaults, strap order {aging, pause, backoff}
// ********************************************************
`define SGC_GC0_RESET 3'h4
`define SGC_GC1_RESET 8'h04
`define SGC_STRAP_PULL 3'h4
`define SGC_STRAP_SETTLE 3'h4
// ********************************************************
// Frame constants and buffer pool
// ********************************************************
`define SGC_PAUSE_TYPE 16'h8808
`define SGC_PAUSE_DA 48'h0180C2000001
`define SGC_MAX_LEN 16'h05DC
`define SGC_POOL_BLOCKS 16'h0500
`define SGC_POOL_FIFTH (`SGC_POOL_BLOCKS / 16'h0005)
// ********************************************************
// Timing
// ********************************************************
`define SGC_CLK_MHZ 50
`define SGC_US_CYCLES 6'(`SGC_CLK_MHZ)
`define SGC_AGE_FAST_US 800
`define SGC_AGE_NORMAL_S 300
`endif

/* File: pkg/sgc_pkg.sv */
// Types shared by the global switch control block.
package sgc_pkg;
    // ********************************************************
    // Frame header and verdict carriers
    // ********************************************************
    typedef struct packed
    {
        logic valid;
        logic [15:0] type_len;
        logic [47:0] dest;
        logic [15:0] actual_len;
        logic flow_ctrl;
        logic errored;
    } sgc_frame_t;
    typedef struct packed
    {
        logic valid;
        logic forward;
    } sgc_verdict_t;
    // ********************************************************
    // Aging states and module state records
    // ********************************************************
    typedef enum logic [2:0] {SGC_AGE_NORMAL = 3'h1, SGC_AGE_FAST_WAIT = 3'h2, SGC_AGE_FAST_PASS = 3'h4} sgc_age_t;
    typedef struct packed
    {
        logic [5:0] pre;
        logic [31:0] count;
        logic fast_q;
        logic tick;
    } sgc_timer_t;
    typedef struct packed
    {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] value;
    } sgc_sync_t;
    typedef struct packed
    {
        logic loaded;
        logic [2:0] settle;
        logic [2:0] gc0;
        logic [7:0] gc1;
        logic [31:0] prdata;
        logic pslverr;
        sgc_verdict_t verdict;
        logic [4:0] tx_en;
        logic [4:0] rx_en;
        logic [4:0] grant;
        logic [4:0] link_q;
        sgc_age_t age;
        logic busy;
        logic age_start;
        logic flush;
    } sgc_top_t;
endpackage

/* File: sim/sgc_tb.sv */
// Self-checking testbench for the global switch control block.
`timescale 1ns/1ps
module testbench
    import sgc_pkg::*;
;
    // ********
    // Signals: straps all high so every strap bit reads back as one.
    // ********
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pause_disable_strap_pin = 1'b1;
    logic backoff_strap_pin = 1'b1;
    logic aging_strap_pin = 1'b1;
    sgc_frame_t frame_in = '0;
    logic [4:0][15:0] port_buf_used = {16'h0500, 16'h04FF, 16'h0100, 16'h00FF, 16'h0000};
    logic [4:0] an_tx_pause = 5'h15;
    logic [4:0] an_rx_pause = 5'h0A;
    logic [4:0] port_link = 5'h1F;
    logic age_done = 1'b0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, err_q, aggressive_backoff, age_start, flush_all, switch_ready;
    sgc_verdict_t verdict_out;
    logic [4:0] buf_grant, tx_pause_en, rx_pause_en;
    int err_total = 0;
    int n_tests = 0;
    int cyc;
    // One table row: register settings, frame header and the expected forward decision.
    typedef struct packed
    {
        logic [7:0] gc0;
        logic [7:0] gc1;
        logic [15:0] tl;
        logic pda;
        logic [15:0] al;
        logic fc;
        logic er;
        logic fwd;
    } sgc_row_t;
    sgc_row_t rows [13];

    // Short aging periods keep the run brief: 200 and 1000 cycles.
    sgc_top #(.AGE_FAST_US(4), .AGE_NORMAL_US(20)) u_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .pause_disable_strap_pin, .backoff_strap_pin, .aging_strap_pin, .frame_in, .verdict_out,
        .port_buf_used, .buf_grant, .an_tx_pause, .an_rx_pause, .tx_pause_en, .rx_pause_en,
        .aggressive_backoff, .port_link, .age_start, .age_done, .flush_all, .switch_ready
    );

    // Clock of 20 ns.
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Stands in for the address table: each aging pass ends one cycle after it starts.
    always @(posedge pclk)
    begin
        age_done <= age_start;
    end

    // ********
    // Tasks
    // ********
    // Compares one value with case equality, so unknowns never match.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Checks made %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; waits for pready without assuming a latency.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        rdy = 1'b0;
        while (!rdy && n < 100)
        begin
            @(negedge pclk);
            rdy = (pready === 1'b1);
            @(posedge pclk);
            n++;
        end
        if (!rdy)
        begin
            chk("pready wait", 32'h1, 32'h0);
            tally_and_finish();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts cycles until an aging pass starts, giving up after max cycles.
    task automatic wait_start(input int max);
        cyc = 0;
        do
        begin
            @(negedge pclk);
            cyc++;
        end
        while (age_start !== 1'b1 && cyc < max);
    endtask

    // Drops the links outside mask m for a moment; the flush must be a single cycle pulse.
    task automatic unplug(input logic [4:0] m);
        @(posedge pclk);
        port_link <= m;
        @(posedge pclk);
        @(negedge pclk);
        chk("flush pulse", 32'h1, 32'(flush_all));
        @(negedge pclk);
        chk("flush end", 32'h0, 32'(flush_all));
        @(posedge pclk);
        port_link <= 5'h1F;
    endtask

    // ********
    // Sequence: reset and register cases first, then the table of frames, then aging cases.
    // ********
    initial
    begin
        rows = '{
            '{8'h00, 8'h04, 16'h0800, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b1},
            '{8'h00, 8'h04, 16'h8808, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b1},
            '{8'h00, 8'h04, 16'h0800, 1'b1, 16'h0040, 1'b0, 1'b0, 1'b1},
            '{8'h00, 8'h04, 16'h0800, 1'b0, 16'h0040, 1'b1, 1'b0, 1'b0},
            '{8'h02, 8'h04, 16'h8808, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b0},
            '{8'h02, 8'h04, 16'h0800, 1'b1, 16'h0040, 1'b0, 1'b0, 1'b0},
            '{8'h02, 8'h04, 16'h0800, 1'b0, 16'h0040, 1'b1, 1'b0, 1'b1},
            '{8'h00, 8'h0C, 16'h0040, 1'b0, 16'h0041, 1'b0, 1'b0, 1'b0},
            '{8'h00, 8'h0C, 16'h0040, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b1},
            '{8'h00, 8'h0C, 16'h05DC, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b1},
            '{8'h00, 8'h0C, 16'h05DB, 1'b0, 16'h0040, 1'b0, 1'b0, 1'b0},
            '{8'h00, 8'h04, 16'h0800, 1'b0, 16'h0040, 1'b0, 1'b1, 1'b0},
            '{8'h02, 8'h84, 16'h8808, 1'b0, 16'h0041, 1'b1, 1'b1, 1'b1}};
        repeat (12) @(posedge pclk);
        chk("ready in reset", 32'h0, 32'(switch_ready));
        presetn <= 1'b1;
        wait_start(0);
        for (cyc = 0; cyc < 20 && switch_ready !== 1'b1; cyc++)
            @(negedge pclk);
        chk("switch ready", 32'h1, 32'(switch_ready));
        apb(1'b0, 12'h00C, 32'h0, 4'hF);
        chk("strap defaults", 32'h35, rd_q);
        chk("backoff strap", 32'h1, 32'(aggressive_backoff));
        chk("tx pause strap", 32'h0, 32'(tx_pause_en));
        chk("rx pause strap", 32'h0, 32'(rx_pause_en));
        apb(1'b0, 12'h008, 32'h0, 4'hF);
        chk("share default", 32'h4, rd_q);
        chk("shared grants", 32'h0F, 32'(buf_grant));
        apb(1'b1, 12'h008, 32'hFFFFFFFF, 4'hE);
        apb(1'b0, 12'h008, 32'h0, 4'hF);
        chk("strobe off", 32'h4, rd_q);
        apb(1'b1, 12'h008, 32'hFFFFFFFF, 4'hF);
        apb(1'b0, 12'h008, 32'h0, 4'hF);
        chk("upper bits", 32'h7, rd_q);
        apb(1'b1, 12'h008, 32'h0, 4'hF);
        repeat (2) @(negedge pclk);
        chk("fifth grants", 32'h03, 32'(buf_grant));
        apb(1'b0, 12'h010, 32'h0, 4'hF);
        chk("unmapped error", 32'h1, 32'(err_q));
        chk("unmapped data", 32'h0, rd_q);
        apb(1'b1, 12'h00C, 32'h24, 4'hF);
        repeat (2) @(negedge pclk);
        chk("tx off", 32'h00, 32'(tx_pause_en));
        chk("rx on", 32'h0A, 32'(rx_pause_en));
        apb(1'b1, 12'h00C, 32'h14, 4'hF);
        repeat (2) @(negedge pclk);
        chk("tx on", 32'h15, 32'(tx_pause_en));
        chk("rx off", 32'h00, 32'(rx_pause_en));
        apb(1'b1, 12'h00C, 32'h04, 4'hF);
        @(negedge pclk);
        chk("backoff off", 32'h0, 32'(aggressive_backoff));
        foreach (rows[i])
        begin
            apb(1'b1, 12'h008, {24'h0, rows[i].gc0}, 4'hF);
            apb(1'b1, 12'h00C, {24'h0, rows[i].gc1}, 4'hF);
            @(posedge pclk);
            frame_in <= '{1'b1, rows[i].tl, rows[i].pda ? 48'h0180C2000001 : 48'h00AA00BB00CC,
                          rows[i].al, rows[i].fc, rows[i].er};
            @(posedge pclk);
            frame_in <= '0;
            @(negedge pclk);
            chk("verdict valid", 32'h1, 32'(verdict_out.valid));
            chk("forward", 32'(rows[i].fwd), 32'(verdict_out.forward));
        end
        apb(1'b1, 12'h008, 32'h0, 4'hF);
        apb(1'b1, 12'h00C, 32'h06, 4'hF);
        wait_start(1200);
        wait_start(300);
        chk("fast period", 32'h1, 32'(cyc >= 198 && cyc <= 202));
        apb(1'b1, 12'h00C, 32'h04, 4'hF);
        wait_start(1200);
        wait_start(1200);
        chk("normal period", 32'h1, 32'(cyc >= 995 && cyc <= 1005));
        apb(1'b1, 12'h00C, 32'h00, 4'hF);
        unplug(5'h1E);
        wait_start(1500);
        chk("aging off", 32'h0, 32'(age_start));
        apb(1'b1, 12'h008, 32'h1, 4'hF);
        apb(1'b1, 12'h00C, 32'h04, 4'hF);
        wait_start(1200);
        unplug(5'h1B);
        wait_start(210);
        chk("link fast pass", 32'h1, 32'(age_start));
        wait_start(1200);
        chk("back to normal", 32'h1, 32'(cyc >= 990 && cyc <= 1010));
        tally_and_finish();
    end
endmodule

/* File: verilog/sgc_age_timer.sv */
// Aging period timer: microsecond prescaler and period counter.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_age_timer
    import sgc_pkg::*;
#(
    parameter int unsigned FAST_US = `SGC_AGE_FAST_US,
    parameter int unsigned NORMAL_US = `SGC_AGE_NORMAL_S * 1000000
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic fast,
    output logic tick
);
    sgc_timer_t s; // Whole state of the timer.
    sgc_timer_t next_s; // Next state.
    logic us_en; // One-cycle pulse each microsecond.
    logic [31:0] period; // Period in microseconds for the active mode.
    // The count restarts on a mode change so a fast period never waits out a normal one.
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.fast_q = fast;
        us_en = (s.pre == (`SGC_US_CYCLES - 6'h01));
        period = fast ? 32'(FAST_US) : 32'(NORMAL_US);
        next_s.pre = us_en ? 6'h00 : s.pre + 6'h01;
        if (!enable || (fast != s.fast_q))
        begin
            next_s.count = 32'h0;
        end
        else if (us_en)
        begin
            if (s.count >= period - 32'h1)
            begin
                next_s.count = 32'h0;
                next_s.tick = 1'b1;
            end
            else
            begin
                next_s.count = s.count + 32'h1;
            end
        end
    end
    // Registers the timer state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
    assign tick = s.tick;
endmodule

/* File: verilog/sgc_strap_sync.sv */
// Three-stage synchroniser and settle filter for the strap pins.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_strap_sync
    import sgc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] strap_pin,
    output logic [2:0] strap_value
);
    sgc_sync_t s; // Whole state of the synchroniser.
    sgc_sync_t next_s; // Next state.
    // A bit only changes once stages two and three agree, so a glitch never lands.
    always_comb
    begin
        next_s = s;
        next_s.s1 = strap_pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.value = (s.value & (s.s2 ^ s.s3)) | (s.s3 & ~(s.s2 ^ s.s3));
    end
    // Reset loads the internal pull levels.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{s1: `SGC_STRAP_PULL, s2: `SGC_STRAP_PULL, s3: `SGC_STRAP_PULL, value: `SGC_STRAP_PULL};
        end
        else
        begin
            s <= next_s;
        end
    end
    assign strap_value = s.value;
endmodule

/* File: verilog/sgc_top.sv */
// Global switch control registers over APB with frame, pause, buffer and aging control.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
// How it works
// - Sharing lets a port use whole pool.
// - Filter mode drops pause type or address.
// - Otherwise drop only classified flow-control frames.
// - Link loss triggers one fast aging pass.
// - After that pass, return to normal period.
// - Any unplug flushes all learned addresses.
// - Pass-all forwards every frame, errored too.
// - Transmit pause follows negotiation unless disabled.
// - Receive pause follows negotiation unless disabled.
// - One strap sets both pause disable bits.
// - Length check drops mismatched short frames.
// - Aging runs only while enabled; strap default.
// - Fast age bit selects short period.
// - Aggressive back-off bit, strap default off.
module sgc_top
    import sgc_pkg::*;
#(
    parameter int unsigned AGE_FAST_US = `SGC_AGE_FAST_US,
    parameter int unsigned AGE_NORMAL_US = `SGC_AGE_NORMAL_S * 1000000
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pause_disable_strap_pin,
    input wire logic backoff_strap_pin,
    input wire logic aging_strap_pin,
    input wire sgc_frame_t frame_in,
    output sgc_verdict_t verdict_out,
    input wire logic [4:0][15:0] port_buf_used,
    output logic [4:0] buf_grant,
    input wire logic [4:0] an_tx_pause,
    input wire logic [4:0] an_rx_pause,
    output logic [4:0] tx_pause_en,
    output logic [4:0] rx_pause_en,
    output logic aggressive_backoff,
    input wire logic [4:0] port_link,
    output logic age_start,
    input wire logic age_done,
    output logic flush_all,
    output logic switch_ready
);
    // ********************************************************
    // Declarations
    // ********************************************************
    sgc_top_t s; // Whole state of the block.
    sgc_top_t next_s; // Next state.
    logic [2:0] strap; // Settled straps, {aging, pause, backoff}.
    logic age_tick; // One-cycle pulse at the end of an aging period.
    logic timer_fast; // Selects the short aging period.
    logic [15:0] buf_limit; // Per-port buffer ceiling.
    logic [4:0] grant_d; // Per-port grant before the register.
    logic hit0; // Address selects the first control register.
    logic hit1; // Address selects the second control register.
    logic [31:0] rd_word; // Read data for the decoded address.
    logic pause_hit; // Frame matches the pause filter.
    logic len_bad; // Frame fails the length check.
    logic link_drop; // Some port went from link to no link.
    logic age_en; // Aging enable bit.

    // ********************************************************
    // Strap synchroniser and aging timer
    // ********************************************************
    sgc_strap_sync u_strap
    (
        .pclk(pclk),
        .presetn(presetn),
        .strap_pin({aging_strap_pin, pause_disable_strap_pin, backoff_strap_pin}),
        .strap_value(strap)
    );

    // The timer sees the fast mode during a link-triggered pass, too.
    assign timer_fast = s.gc1[`SGC_B_FASTAGE] || (s.age != SGC_AGE_NORMAL);
    sgc_age_timer #(
        .FAST_US(AGE_FAST_US),
        .NORMAL_US(AGE_NORMAL_US)
    ) u_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .enable(s.gc1[`SGC_B_AGEEN]),
        .fast(timer_fast),
        .tick(age_tick)
    );

    // ********************************************************
    // Per-port buffer grants
    // ********************************************************
    // Without sharing a port stops at a fifth, even when the pool is idle.
    assign buf_limit = s.gc0[`SGC_B_SHARE] ? `SGC_POOL_BLOCKS : `SGC_POOL_FIFTH;
    for (genvar i = 0; i < 5; i++)
    begin : g_grant
        assign grant_d[i] = (port_buf_used[i] < buf_limit);
    end

    // ********************************************************
    // Combinational decode
    // ********************************************************
    assign hit0 = (paddr == `SGC_ADDR_GC0);
    assign hit1 = (paddr == `SGC_ADDR_GC1);
    assign age_en = s.gc1[`SGC_B_AGEEN];
    assign link_drop = |(s.link_q & ~port_link);
    // Unimplemented upper bits read as zero.
    assign rd_word = hit0 ? {29'h0, s.gc0} : (hit1 ? {24'h0, s.gc1} : 32'h0);
    // Filter mode matches the literal fields, else trust the classifier.
    assign pause_hit = s.gc0[`SGC_B_FILTER] ?
        ((frame_in.type_len == `SGC_PAUSE_TYPE) || (frame_in.dest == `SGC_PAUSE_DA)) :
        frame_in.flow_ctrl;
    assign len_bad = s.gc1[`SGC_B_LENCHK] && (frame_in.type_len < `SGC_MAX_LEN) &&
        (frame_in.actual_len != frame_in.type_len);

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb
    begin
        next_s = s;
        next_s.age_start = 1'b0;
        next_s.flush = 1'b0;
        // Straps settle through the synchroniser before they are captured.
        if (!s.loaded)
        begin
            if (s.settle == `SGC_STRAP_SETTLE)
            begin
                next_s.loaded = 1'b1;
                next_s.gc1[`SGC_B_TXDIS] = strap[1];
                next_s.gc1[`SGC_B_RXDIS] = strap[1];
                next_s.gc1[`SGC_B_AGEEN] = strap[2];
                next_s.gc1[`SGC_B_BACKOFF] = strap[0];
            end
            else
            begin
                next_s.settle = s.settle + 3'h1;
            end
        end
        // Setup captures read data; wait states refresh it up to the strap load edge, so a held read returns the pre-strap word.
        if (psel && (!penable || !s.loaded))
        begin
            next_s.prdata = rd_word;
            next_s.pslverr = !(hit0 || hit1);
        end
        // Writes land only at the access edge; bits change independently.
        if (psel && penable && s.loaded && pwrite && pstrb[0])
        begin
            if (hit0)
            begin
                next_s.gc0 = pwdata[2:0];
            end
            else if (hit1)
            begin
                next_s.gc1 = pwdata[7:0];
            end
        end
        // Frame verdict, one cycle after the header.
        next_s.verdict.valid = frame_in.valid;
        if (s.gc1[`SGC_B_PASSALL])
        begin
            next_s.verdict.forward = 1'b1;
        end
        else
        begin
            next_s.verdict.forward = !(pause_hit || len_bad || frame_in.errored);
        end
        // Pause enables follow negotiation unless software disables them.
        next_s.tx_en = s.gc1[`SGC_B_TXDIS] ? 5'h00 : an_tx_pause;
        next_s.rx_en = s.gc1[`SGC_B_RXDIS] ? 5'h00 : an_rx_pause;
        next_s.grant = grant_d;
        // Any unplug flushes the table, whatever the aging bits say.
        next_s.link_q = port_link;
        next_s.flush = link_drop;
        // Done clears busy; a start in the same cycle wins below.
        if (age_done)
        begin
            next_s.busy = 1'b0;
        end
        unique case (s.age)
            SGC_AGE_NORMAL:
            begin
                // A link loss hands over to the fast one-shot pass.
                if (link_drop && s.gc0[`SGC_B_LINKAGE] && age_en)
                begin
                    next_s.age = SGC_AGE_FAST_WAIT;
                end
                else if (age_tick && age_en && !s.busy)
                begin
                    next_s.age_start = 1'b1;
                    next_s.busy = 1'b1;
                end
            end
            SGC_AGE_FAST_WAIT:
            begin
                // Disabling aging abandons the pending fast pass.
                if (!age_en)
                begin
                    next_s.age = SGC_AGE_NORMAL;
                end
                else if (age_tick && !s.busy)
                begin
                    next_s.age_start = 1'b1;
                    next_s.busy = 1'b1;
                    next_s.age = SGC_AGE_FAST_PASS;
                end
            end
            SGC_AGE_FAST_PASS:
            begin
                if (age_done)
                begin
                    next_s.age = SGC_AGE_NORMAL;
                end
            end
            default:
            begin
                next_s.age = SGC_AGE_NORMAL;
            end
        endcase
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{loaded: 1'b0, settle: 3'h0, gc0: `SGC_GC0_RESET, gc1: `SGC_GC1_RESET, prdata: 32'h0,
                   pslverr: 1'b0, verdict: '0, tx_en: 5'h00, rx_en: 5'h00, grant: 5'h00, link_q: 5'h00,
                   age: SGC_AGE_NORMAL, busy: 1'b0, age_start: 1'b0, flush: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Wait states hold software off until straps are in.
    assign pready = s.loaded;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign verdict_out = s.verdict;
    assign buf_grant = s.grant;
    assign tx_pause_en = s.tx_en;
    assign rx_pause_en = s.rx_en;
    assign aggressive_backoff = s.gc1[`SGC_B_BACKOFF];
    assign age_start = s.age_start;
    assign flush_all = s.flush;
    assign switch_ready = s.loaded;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    fifth_limit_a: assert property (!s.gc0[`SGC_B_SHARE] && (port_buf_used[2] >= `SGC_POOL_FIFTH)
        |=> !buf_grant[2]) else $error("Unshared port granted above a fifth.");
    pause_type_a: assert property (frame_in.valid && s.gc0[`SGC_B_FILTER] && !s.gc1[`SGC_B_PASSALL]
        && (frame_in.type_len == `SGC_PAUSE_TYPE) |=> verdict_out.valid && !verdict_out.forward)
        else $error("Pause type frame forwarded in filter mode.");
    flow_drop_a: assert property (frame_in.valid && !s.gc0[`SGC_B_FILTER] && !s.gc1[`SGC_B_PASSALL]
        && !frame_in.flow_ctrl && !frame_in.errored && !len_bad |=> verdict_out.forward)
        else $error("Non flow-control frame dropped.");
    link_fast_a: assert property ((s.age == SGC_AGE_NORMAL) && link_drop && s.gc0[`SGC_B_LINKAGE]
        && age_en |=> (s.age == SGC_AGE_FAST_WAIT) && timer_fast)
        else $error("Link loss did not start fast aging.");
    back_normal_a: assert property ((s.age == SGC_AGE_FAST_PASS) && age_done
        |=> (s.age == SGC_AGE_NORMAL)) else $error("Aging stayed fast after the pass.");
    unplug_flush_a: assert property ((s.link_q[2] && !port_link[2]) |=> flush_all ##1 !flush_all)
        else $error("Unplug did not flush once.");
    pass_all_a: assert property (frame_in.valid && s.gc1[`SGC_B_PASSALL]
        |=> verdict_out.valid && verdict_out.forward) else $error("Pass-all dropped a frame.");
    tx_pause_a: assert property (s.gc1[`SGC_B_TXDIS] |=> (tx_pause_en == 5'h00))
        else $error("Transmit pause enabled while disabled.");
    rx_pause_a: assert property (!s.gc1[`SGC_B_RXDIS]
        |=> (rx_pause_en == $past(an_rx_pause))) else $error("Receive pause ignored negotiation.");
    strap_pair_a: assert property ($rose(switch_ready) |-> (s.gc1[`SGC_B_TXDIS] == s.gc1[`SGC_B_RXDIS]))
        else $error("Pause disable bits loaded apart.");
    len_drop_a: assert property (frame_in.valid && len_bad && !s.gc1[`SGC_B_PASSALL]
        |=> !verdict_out.forward) else $error("Length mismatch forwarded.");
    age_gate_a: assert property (!age_en |=> !age_start)
        else $error("Aging pass started while disabled.");
    ready_hold_a: assert property (!switch_ready |-> !pready ##[1:8] switch_ready)
        else $error("Bus answered early or straps loaded late.");
endmodule
